// >>> rtl/icsc_pkg.sv
// Constants for the interrupt status collector: register offsets, bit positions,
// valid-bit masks and reset values.
// Assumes a single core clock domain and a 32-bit internal register address.
package icsc_pkg;

   // ==========================================================================
   // Register map
   localparam logic [31:0] ICSC_SYS_STATUS_1_ADDR   = 32'h0B00_0080;
   localparam logic [31:0] ICSC_TOUCH_STATUS_ADDR   = 32'h0B00_0082;
   localparam logic [15:0] ICSC_STATUS_RESET        = 16'h0000;

   // ==========================================================================
   // Level-1 system status bit positions
   localparam int ICSC_BIT_BATTERY       = 0;
   localparam int ICSC_BIT_POWER_SWITCH  = 1;
   localparam int ICSC_BIT_LONG_ONE      = 2;
   localparam int ICSC_BIT_EXT_TIMER     = 3;
   localparam int ICSC_BIT_TOUCH_UNIT    = 5;
   localparam int ICSC_BIT_AUDIO         = 6;
   localparam int ICSC_BIT_KEYBOARD      = 7;
   localparam int ICSC_BIT_GENERAL_IO    = 8;
   localparam int ICSC_BIT_SERIAL        = 9;
   localparam int ICSC_BIT_BUS_ERROR     = 10;
   localparam int ICSC_BIT_SOFTWARE      = 11;
   localparam int ICSC_BIT_TOUCH_SUSPEND = 13;
   localparam logic [15:0] ICSC_SYS_VALID_MASK = 16'h2FEF;

   // ==========================================================================
   // Touch-panel status bit positions
   localparam int ICSC_BIT_CONTACT_CHANGE = 0;
   localparam int ICSC_BIT_SAMPLE_TIMEOUT = 2;
   localparam int ICSC_BIT_PAGE_ZERO      = 3;
   localparam int ICSC_BIT_PAGE_ONE       = 4;
   localparam int ICSC_BIT_PORT_SCAN      = 5;
   localparam int ICSC_BIT_COMMAND_SCAN   = 6;
   localparam int ICSC_TOUCH_WIDTH        = 7;
   localparam logic [6:0]  ICSC_TOUCH_VALID_MASK = 7'h7D;

endpackage : icsc_pkg

// >>> rtl/icsc_flag_bank.sv
// Bank of sticky event flags, one flip-flop per bit.
// Assumes set and clear arrive as synchronous one-cycle pulses on the core clock.
module icsc_flag_bank #(
   parameter int WIDTH = 7
) (
   input  wire logic             core_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             clr_all_in,
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clear_in,
   output logic      [WIDTH-1:0] flags_out
);

   // ==========================================================================
   // Per-bit sticky flags
   // A set in the same cycle as a single-bit clear wins, so no event is lost;
   // the whole-bank reset clear still dominates.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_flag
         always_ff @(posedge core_clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
               flags_out[i] <= 1'b0;
            end else if (clr_all_in) begin
               flags_out[i] <= 1'b0;
            end else if (set_in[i]) begin
               flags_out[i] <= 1'b1;
            end else if (clear_in[i]) begin
               flags_out[i] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule // icsc_flag_bank

// >>> rtl/icsc_collector.sv
// Interrupt status collector: level-1 system status and touch-panel status
// registers, read by the core, with masked requests driven to the core.
// Assumes all inputs are synchronous to core_clk_in and event inputs are pulses.
//
// Summary of operation
// - Reserved bits of both status registers always read as zero and writes must put zero there.
// - System status bits 10,9,8,7,6,5,3,2,1,0 flag bus error, serial, general I/O, keyboard, audio, touch, timer, long interval one, power switch and battery.
// - System status bit 13 sets when the touch unit requests an interrupt while in Suspend.
// - System status bit 11 shows the software request register being set.
// - Touch status bit 6 sets when a command scan finds valid data.
// - Touch status bit 5 sets when the converter port scan finds a full valid set.
// - Touch status bit 4 sets when a full valid set lands in buffer page one.
// - Touch status bit 3 sets when a full valid set lands in buffer page zero.
// - Touch status bit 2 sets when a full data set is not obtained in time.
// - Touch status bit 0 sets on a pen contact change and reads zero otherwise.
// - Touch status flags are read-only, one means occurred, bits 15 to 7 reserved.
// - Touch flags gated by their mask bits combine into the single touch bit of system status.
// - Each system status bit gated by its mask bit is the only path to line 0; battery reaches the non-maskable line without its mask bit.
// - Battery goes to the non-maskable line or line 0 by the route select, the rest to line 0.
module icsc_collector (
   input  wire logic                   core_clk_in,
   input  wire logic                   reset_n_in,
   input  wire logic                   realtime_clock_reset_in,
   input  wire logic [31:0]            reg_addr_in,
   input  wire logic                   reg_rd_in,
   input  wire logic                   reg_wr_in,
   output logic      [15:0]            reg_rdata_out,
   output logic                        reg_ack_out,
   input  wire logic [icsc_pkg::ICSC_TOUCH_WIDTH-1:0] touch_event_in,
   input  wire logic [icsc_pkg::ICSC_TOUCH_WIDTH-1:0] touch_clear_in,
   input  wire logic [icsc_pkg::ICSC_TOUCH_WIDTH-1:0] touch_mask_in,
   input  wire logic                   suspend_in,
   input  wire logic                   touch_suspend_clear_in,
   input  wire logic                   software_request_in,
   input  wire logic                   bus_error_flag_in,
   input  wire logic                   serial_unit_flag_in,
   input  wire logic                   general_io_flag_in,
   input  wire logic                   keyboard_unit_flag_in,
   input  wire logic                   audio_unit_flag_in,
   input  wire logic                   extended_timer_flag_in,
   input  wire logic                   long_interval_one_flag_in,
   input  wire logic                   power_switch_flag_in,
   input  wire logic                   battery_flag_in,
   input  wire logic [15:0]            system_mask_1_in,
   input  wire logic                   battery_route_select_in,
   output logic                        core_int0_out,
   output logic                        core_nmi_out
);
   import icsc_pkg::*;

   // ==========================================================================
   // Declarations
   logic [ICSC_TOUCH_WIDTH-1:0] touch_flags;
   logic [15:0]                 touch_status;
   logic [15:0]                 sys_status_reg;
   logic [15:0]                 sys_status_next;
   logic                        touch_suspend_reg;
   logic [15:0]                 rdata_reg;
   logic [15:0]                 rdata_next;
   logic                        ack_reg;
   logic                        int0_reg;
   logic                        int0_next;
   logic                        nmi_reg;
   logic                        nmi_next;
   logic                        touch_any;
   logic [15:0]                 sys_enabled;
   logic                        hit_sys;
   logic                        hit_touch;

   // ==========================================================================
   // Touch-panel status flags
   // Reserved bit 1 never sets, whatever the unit drives on it
   icsc_flag_bank #(
      .WIDTH (ICSC_TOUCH_WIDTH)
   ) u_touch_flags (
      .core_clk_in (core_clk_in),
      .reset_n_in  (reset_n_in),
      .clr_all_in  (realtime_clock_reset_in),
      .set_in      (touch_event_in
                    & ICSC_TOUCH_VALID_MASK),
      .clear_in    (touch_clear_in),
      .flags_out   (touch_flags)
   );

   // Zero-extend so bits 15 to 7 read as zero
   assign touch_status = {9'h000, touch_flags & ICSC_TOUCH_VALID_MASK};

   // ==========================================================================
   // Level-1 composition
   // Touch flags are masked first and collapse into one unit bit
   assign touch_any = |(touch_flags & touch_mask_in);

   always_comb begin
      sys_status_next                        = ICSC_STATUS_RESET;
      sys_status_next[ICSC_BIT_BATTERY]      = battery_flag_in;
      sys_status_next[ICSC_BIT_POWER_SWITCH] = power_switch_flag_in;
      sys_status_next[ICSC_BIT_LONG_ONE]     = long_interval_one_flag_in;
      sys_status_next[ICSC_BIT_EXT_TIMER]    = extended_timer_flag_in;
      sys_status_next[ICSC_BIT_TOUCH_UNIT]   = touch_any;
      sys_status_next[ICSC_BIT_AUDIO]        = audio_unit_flag_in;
      sys_status_next[ICSC_BIT_KEYBOARD]     = keyboard_unit_flag_in;
      sys_status_next[ICSC_BIT_GENERAL_IO]   = general_io_flag_in;
      sys_status_next[ICSC_BIT_SERIAL]       = serial_unit_flag_in;
      sys_status_next[ICSC_BIT_BUS_ERROR]    = bus_error_flag_in;
      sys_status_next[ICSC_BIT_SOFTWARE]     = software_request_in;
      sys_status_next[ICSC_BIT_TOUCH_SUSPEND] = touch_suspend_reg;
   end

   // Suspend-time touch flag is sticky so a wake-up cause survives the exit
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         touch_suspend_reg <= 1'b0;
      end else if (realtime_clock_reset_in) begin
         touch_suspend_reg <= 1'b0;
      end else if (suspend_in && touch_any) begin
         touch_suspend_reg <= 1'b1;
      end else if (touch_suspend_clear_in) begin
         touch_suspend_reg <= 1'b0;
      end
   end

   // System status register, reserved bits forced low
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sys_status_reg <= ICSC_STATUS_RESET;
      end else if (realtime_clock_reset_in) begin
         sys_status_reg <= ICSC_STATUS_RESET;
      end else begin
         sys_status_reg <= sys_status_next & ICSC_SYS_VALID_MASK;
      end
   end

   // ==========================================================================
   // Requests toward the core
   // Battery is excluded from line 0 only while routed to the non-maskable line
   assign sys_enabled = sys_status_reg & system_mask_1_in;
   assign int0_next   = |(sys_enabled & ~16'h0001)
                        | (sys_enabled[ICSC_BIT_BATTERY] & ~battery_route_select_in);
   // The non-maskable line ignores the level-1 mask; software masks it by rerouting
   assign nmi_next    = sys_status_reg[ICSC_BIT_BATTERY] & battery_route_select_in;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         int0_reg <= 1'b0;
         nmi_reg  <= 1'b0;
      end else begin
         int0_reg <= int0_next;
         nmi_reg  <= nmi_next;
      end
   end

   // ==========================================================================
   // Register read port
   // Writes are accepted and dropped; both registers are read-only
   assign hit_sys    = (reg_addr_in == ICSC_SYS_STATUS_1_ADDR);
   assign hit_touch  = (reg_addr_in == ICSC_TOUCH_STATUS_ADDR);
   assign rdata_next = hit_sys   ? sys_status_reg :
                       hit_touch ? touch_status   : 16'h0000;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_reg <= 16'h0000;
         ack_reg   <= 1'b0;
      end else begin
         ack_reg <= reg_rd_in | reg_wr_in;
         if (reg_rd_in) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign reg_ack_out   = ack_reg;
   assign core_int0_out = int0_reg;
   assign core_nmi_out  = nmi_reg;

   // ==========================================================================
   // Checks
   sys_reserved_zero_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (sys_status_reg & ~ICSC_SYS_VALID_MASK) == 16'h0000)
      else $error("reserved system status bit set");

   touch_reserved_zero_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && hit_touch |=> reg_rdata_out[15:7] == 9'h000 && !reg_rdata_out[1])
      else $error("reserved touch status bit read nonzero");

   battery_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[0] == $past(battery_flag_in))
      else $error("battery bit does not follow its source");

   suspend_touch_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      suspend_in && touch_any && !realtime_clock_reset_in ##1 !realtime_clock_reset_in
      |=> sys_status_reg[13])
      else $error("suspend touch flag not set");

   software_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      software_request_in && !realtime_clock_reset_in |=> sys_status_reg[11])
      else $error("software flag missing");

   command_scan_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      touch_event_in[6] && !realtime_clock_reset_in |=> touch_flags[6])
      else $error("command scan flag not set");

   touch_events_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=>
      (touch_flags & $past(touch_event_in) & ICSC_TOUCH_VALID_MASK)
      == ($past(touch_event_in) & ICSC_TOUCH_VALID_MASK))
      else $error("touch event lost");

   touch_aggregate_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[5] == $past(touch_any))
      else $error("touch unit bit does not match masked flags");

   int0_gate_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (sys_status_reg & system_mask_1_in & 16'hFFFE) == 16'h0000
      && !(sys_status_reg[0] && system_mask_1_in[0])
      |=> !core_int0_out)
      else $error("line 0 raised with nothing enabled");

   nmi_route_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      sys_status_reg[0] |=> core_nmi_out == $past(battery_route_select_in))
      else $error("battery not routed as selected");

   rtc_clear_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      realtime_clock_reset_in |=> sys_status_reg == 16'h0000 && touch_flags == 7'h00)
      else $error("flags survive real-time-clock reset");

   write_ignored_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      reg_wr_in && !reg_rd_in |=> $stable(reg_rdata_out) && reg_ack_out)
      else $error("write disturbed read data or went unanswered");

   // Direct sources mirror their inputs one edge later, bit for bit
   power_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[1] == $past(power_switch_flag_in))
      else $error("power switch bit does not follow its source");

   long_one_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[2] == $past(long_interval_one_flag_in))
      else $error("long interval bit does not follow its source");

   timer_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[3] == $past(extended_timer_flag_in))
      else $error("extended timer bit does not follow its source");

   audio_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[6] == $past(audio_unit_flag_in))
      else $error("audio bit does not follow its source");

   keyboard_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[7] == $past(keyboard_unit_flag_in))
      else $error("keyboard bit does not follow its source");

   general_io_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[8] == $past(general_io_flag_in))
      else $error("general io bit does not follow its source");

   serial_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[9] == $past(serial_unit_flag_in))
      else $error("serial bit does not follow its source");

   bus_error_bit_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      !realtime_clock_reset_in |=> sys_status_reg[10] == $past(bus_error_flag_in))
      else $error("bus error bit does not follow its source");

   // Sticky flags hold until their own clear, so a late read still sees the event
   suspend_hold_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      touch_suspend_reg && !touch_suspend_clear_in && !realtime_clock_reset_in |=> touch_suspend_reg)
      else $error("suspend touch flag dropped without a clear");

   contact_hold_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      touch_flags[0] && !touch_clear_in[0] && !realtime_clock_reset_in |=> touch_flags[0])
      else $error("contact change flag dropped without a clear");

   int0_raise_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      (sys_status_reg & system_mask_1_in & 16'hFFFE) != 16'h0000 |=> core_int0_out)
      else $error("enabled request did not raise line 0");

   int0_route_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      sys_status_reg[0] && system_mask_1_in[0]
      && (sys_status_reg & system_mask_1_in & 16'hFFFE) == 16'h0000
      |=> core_int0_out == !$past(battery_route_select_in))
      else $error("battery on line 0 disagrees with route select");

   read_sys_a: assert property (
      @(posedge core_clk_in) disable iff (!reset_n_in)
      reg_rd_in && hit_sys |=> reg_rdata_out == $past(sys_status_reg))
      else $error("system status read returned wrong data");

endmodule // icsc_collector

// >>> verification/icsc_core_model.sv
// Behavioural model of the processor core side of the register bus.
// Assumes the collector takes a request at a rising edge and acks one cycle later.
module icsc_core_model (
   input  wire logic        core_clk_in,
   output logic      [31:0] reg_addr_out,
   output logic             reg_rd_out,
   output logic             reg_wr_out,
   input  wire logic [15:0] reg_rdata_in,
   input  wire logic        reg_ack_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================================
   // Idle bus at time zero
   initial begin
      reg_addr_out = 32'h0000_0000;
      reg_rd_out   = 1'b0;
      reg_wr_out   = 1'b0;
   end

   // One access: request held over the taking edge, answer sampled a cycle later
   task automatic access(input logic [31:0] a, input logic w, output logic [15:0] d,
                         output logic k);
      @(negedge core_clk_in);
      reg_addr_out = a;
      reg_rd_out   = ~w;
      reg_wr_out   = w;  // Writes carry no data, so reserved bits can only be zero
      @(negedge core_clk_in);
      k            = reg_ack_in;
      d            = reg_rdata_in;
      reg_rd_out   = 1'b0;
      reg_wr_out   = 1'b0;
      reg_addr_out = ~a;  // Stale address inverted so nothing relies on it
   endtask
endmodule // icsc_core_model

// >>> verification/tb_top.sv
// Self-checking testbench for the interrupt status collector.
// Assumes a 50 ns core clock and inputs driven on the falling edge.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import icsc_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        rtc_rst, susp, susp_clr, route, rd, wr, ack, int0, nmi;
   logic [6:0]  tev, tclr, tmask;
   logic [15:0] src, smask, rdata;
   logic [31:0] addr;
   int          num_errors = 0;
   int          num_checks = 0;

   always #25 clk = ~clk;

   // ==========================================================================
   // Design and core model
   icsc_collector i_icsc_collector (
      .core_clk_in(clk), .reset_n_in(rst_n), .realtime_clock_reset_in(rtc_rst),
      .reg_addr_in(addr), .reg_rd_in(rd), .reg_wr_in(wr), .reg_rdata_out(rdata),
      .reg_ack_out(ack), .touch_event_in(tev), .touch_clear_in(tclr),
      .touch_mask_in(tmask), .suspend_in(susp), .touch_suspend_clear_in(susp_clr),
      .software_request_in(src[ICSC_BIT_SOFTWARE]), .bus_error_flag_in(src[10]),
      .serial_unit_flag_in(src[9]), .general_io_flag_in(src[8]),
      .keyboard_unit_flag_in(src[7]), .audio_unit_flag_in(src[6]),
      .extended_timer_flag_in(src[3]), .long_interval_one_flag_in(src[2]),
      .power_switch_flag_in(src[1]), .battery_flag_in(src[0]),
      .system_mask_1_in(smask), .battery_route_select_in(route),
      .core_int0_out(int0), .core_nmi_out(nmi));
   icsc_core_model i_icsc_core_model (
      .core_clk_in(clk), .reg_addr_out(addr), .reg_rd_out(rd), .reg_wr_out(wr),
      .reg_rdata_in(rdata), .reg_ack_in(ack));

   // ==========================================================================
   // Shared tasks
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic acc(input logic [31:0] a, input logic w, input logic [15:0] exp);
      logic [15:0] d;
      logic        k;
      i_icsc_core_model.access(a, w, d, k);
      chk("ack", {15'h0000, k}, 16'h0001);
      if (!w) chk("rdata", d, exp);
   endtask

   task automatic pulse_touch(input int n);
      @(negedge clk);
      tev[n] = 1'b1;
      @(negedge clk);
      tev = 7'h00;
   endtask

   task automatic clear_all;
      @(negedge clk);
      tclr     = 7'h7F;
      susp_clr = 1'b1;
      @(negedge clk);
      tclr     = 7'h00;
      susp_clr = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_reset;
      acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, ICSC_STATUS_RESET);
      acc(ICSC_TOUCH_STATUS_ADDR, 1'b0, ICSC_STATUS_RESET);
      acc(32'h0B00_0084, 1'b0, 16'h0000);  // Unmapped place reads zero
      $display("test reset done");
   endtask

   task automatic t_direct;
      int pos[10] = '{0, 1, 2, 3, 6, 7, 8, 9, 10, 11};
      foreach (pos[i]) begin
         @(negedge clk);
         src = 16'h0001 << pos[i];
         repeat (2) @(negedge clk);
         acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, 16'h0001 << pos[i]);
      end
      @(negedge clk);
      src = 16'hFFFF;  // Drives every source, reserved places must stay zero
      repeat (2) @(negedge clk);
      acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, 16'h0FCF);
      src = 16'h0000;
      $display("test direct done");
   endtask

   task automatic t_touch;
      for (int n = 0; n < 7; n++) begin
         pulse_touch(n);
         acc(ICSC_TOUCH_STATUS_ADDR, 1'b0, (n == 1) ? 16'h0000 : 16'h0001 << n);
         clear_all();
      end
      pulse_touch(6);
      acc(ICSC_TOUCH_STATUS_ADDR, 1'b1, 16'h0000);
      acc(ICSC_TOUCH_STATUS_ADDR, 1'b0, 16'h0040);
      @(negedge clk);
      rtc_rst = 1'b1;
      @(negedge clk);
      rtc_rst = 1'b0;
      acc(ICSC_TOUCH_STATUS_ADDR, 1'b0, 16'h0000);
      $display("test touch done");
   endtask

   task automatic t_level;
      @(negedge clk);
      tmask = 7'h01;
      smask = 16'h0020;
      susp  = 1'b1;
      pulse_touch(0);
      repeat (2) @(negedge clk);
      chk("int0", {15'h0000, int0}, 16'h0001);
      acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, 16'h2020);
      susp = 1'b0;
      clear_all();
      chk("int0", {15'h0000, int0}, 16'h0000);
      acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, 16'h0000);
      tmask = 7'h00;  // Level-2 mask off hides the flag from level 1
      pulse_touch(0);
      repeat (2) @(negedge clk);
      acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, 16'h0000);
      clear_all();
      $display("test level done");
   endtask

   task automatic t_route;
      @(negedge clk);
      src   = 16'h0001;
      route = 1'b1;
      smask = 16'h0000;
      repeat (3) @(negedge clk);
      chk("nmi", {15'h0000, nmi}, 16'h0001);
      chk("int0", {15'h0000, int0}, 16'h0000);
      smask = 16'h0001;  // Routed to the non-maskable line, so line 0 stays low
      repeat (2) @(negedge clk);
      chk("int0", {15'h0000, int0}, 16'h0000);
      smask = 16'h0000;
      route = 1'b0;
      repeat (2) @(negedge clk);
      chk("nmi", {15'h0000, nmi}, 16'h0000);
      chk("int0", {15'h0000, int0}, 16'h0000);
      smask = 16'h0001;
      repeat (2) @(negedge clk);
      chk("int0", {15'h0000, int0}, 16'h0001);
      src   = 16'h0000;
      smask = 16'h0000;
      $display("test route done");
   endtask

   task automatic t_rst;
      tmask = 7'h40;
      smask = 16'h0020;
      pulse_touch(6);
      acc(ICSC_TOUCH_STATUS_ADDR, 1'b0, 16'h0040);
      chk("int0", {15'h0000, int0}, 16'h0001);
      rst_n = 1'b0;  // Mid-run reset must wipe the sticky touch flag too
      @(negedge clk);
      rst_n = 1'b1;
      chk("int0", {15'h0000, int0}, 16'h0000);
      chk("rdata", rdata, 16'h0000);
      acc(ICSC_TOUCH_STATUS_ADDR, 1'b0, 16'h0000);
      acc(ICSC_SYS_STATUS_1_ADDR, 1'b0, 16'h0000);
      tmask = 7'h00;
      smask = 16'h0000;
      $display("test mid-run reset done");
   endtask

   // ==========================================================================
   // Verdict, main sequence and watchdog
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      {rtc_rst, susp, susp_clr, route} = 4'h0;
      {tev, tclr, tmask} = 21'h000000;
      {src, smask} = 32'h0000_0000;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_direct();
      t_touch();
      t_level();
      t_route();
      t_rst();
      end_sim();
   end

   // Whole run is well under 400 cycles, so 3000 means a hang
   initial begin
      #(3000 * 50);
      num_errors++;
      end_sim();
   end
endmodule // tb_top
